// ---- hpr_pkg.sv ----
// Shared types and constants of the host port ready logic and its ack glue.
// Assumes one clock, clk_sys, shared by the port logic and the host bus glue.
package hpr_pkg;

	// ==========================================================
	// Register select codes on port_register_select
	localparam logic [1:0] SEL_CONTROL     = 2'h0;
	localparam logic [1:0] SEL_DATA_AUTOINC = 2'h1;
	localparam logic [1:0] SEL_ADDRESS     = 2'h2;
	localparam logic [1:0] SEL_DATA_FIXED  = 2'h3;

	// ==========================================================
	// Field meanings and reset values
	localparam logic HALF_FIRST     = 1'b0;
	localparam logic RW_READ        = 1'b1;
	localparam logic RST_STROBE_N   = 1'b1;
	localparam logic RST_READY_OUT  = 1'b0;
	localparam logic RST_ACK_NODE   = 1'b1;
	localparam logic RST_PIN_SEL_N  = 1'b1;
	localparam int   PORT_PIN_WIDTH = 7;

	// ==========================================================
	// Port side pins of the host port
	typedef struct packed {
		logic       chipSelN;
		logic       strobeA;
		logic       strobeB;
		logic [1:0] regSel;
		logic       halfSel;
		logic       readWrite;
	} hpr_port_pins_t;

	// Host bus controller signals seen by the glue
	typedef struct packed {
		logic chipSelN;
		logic startN;
	} hpr_host_bus_t;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_ACCESS  = 2'b01,
		ST_FETCH   = 2'b10
	} hpr_state_t;

endpackage : hpr_pkg

// ---- hpr_pin_filter.sv ----
// Three-stage input synchroniser with agreement filter.
// Assumes the inputs are asynchronous to clk_sys.
`timescale 1ns/1ns
module hpr_pin_filter #(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             sys_rst,
	// Raw and filtered levels
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinOut
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] flt;
	} hpr_filt_t;

	hpr_filt_t state_ff;
	hpr_filt_t nxt_state;

	// ==========================================================
	// Per-bit agreement: first stage feeds only the second
	always_comb begin
		nxt_state    = state_ff;
		nxt_state.s1 = pinIn;
		nxt_state.s2 = state_ff.s1;
		nxt_state.s3 = state_ff.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (state_ff.s2[i] == state_ff.s3[i]) begin
				nxt_state.flt[i] = state_ff.s3[i];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_ff <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, flt: RST_VAL};
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign pinOut = state_ff.flt;

endmodule : hpr_pin_filter

// ---- hpr_host_port_ready.sv ----
// Host port ready handshake plus the clocked glue making transfer ack.
// Assumes port pins and the ready pin are asynchronous; host bus signals share clk_sys.
// Assumes fetchDone and workDone come from the transfer engine in the clk_sys domain.
//
// What this block does
// - Internal strobe low is XNOR of data strobes ORed with chip select.
// - Ready output is forced low whenever port chip select is high.
// - Ready goes high at chip select fall while earlier work is unfinished.
// - First halfword data read issues a fetch; ready high until word loaded.
// - Strobe rise after second halfword of data write or autoinc read raises busy.
// - Control, address and other accesses leave ready low unless earlier work is unfinished.
// - Ack asserts only when registered ready node and host chip select are low.
// - Each clock, ready node loads chip select OR ready_n OR inverted start.
`timescale 1ns/1ns
module hpr_host_port_ready (
	// Clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   sys_rst,
	// Host port pins
	input  wire hpr_pkg::hpr_port_pins_t portPins,
	output logic                        portReadyOut,
	output logic                        internalPortStrobeN,
	// Internal transfer engine
	output logic                        fetchReq,
	input  wire logic                   fetchDone,
	input  wire logic                   workDone,
	// Host bus glue
	input  wire hpr_pkg::hpr_host_bus_t hostBus,
	input  wire logic                   readyInN,
	output logic                        transferAckN
);

	typedef struct packed {
		hpr_pkg::hpr_state_t phase;
		logic                strobeN;
		logic                busy;
		logic                fetchPend;
		logic                fetchReq;
		logic                readyOut;
		logic                lastHalf;
		logic                bumpOnRise;
		logic                ackNode;
	} hpr_core_t;

	hpr_core_t              state_ff;
	hpr_core_t              nxt_state;
	hpr_pkg::hpr_port_pins_t pinsSync;
	logic                   readySyncN;
	logic                   curStrobeN;
	logic                   strobeFall;
	logic                   strobeRise;
	logic                   isDataReg;
	logic                   isRead;

	// Decoded access from synchronised pins; workPending from busy and fetchPend
	logic                   isAutoInc;
	logic                   isSecondHalf;
	logic                   marksWork;
	logic                   wantsFetch;
	logic                   workPending;

	// ==========================================================
	// Reset images
	// Strobes rest apart under a high select, so leaving reset makes no strobe edge
	localparam hpr_pkg::hpr_port_pins_t PIN_RST = '{
		chipSelN:  hpr_pkg::RST_PIN_SEL_N,
		strobeA:   1'b1,
		strobeB:   1'b0,
		regSel:    hpr_pkg::SEL_CONTROL,
		halfSel:   hpr_pkg::HALF_FIRST,
		readWrite: ~hpr_pkg::RW_READ
	};

	// Ready pin rests at not ready, so no ack leaks out of reset
	localparam logic READY_RST_N = 1'b1;

	// Idle and not ready; ack node high keeps ack negated
	localparam hpr_core_t CORE_RST = '{
		phase:      hpr_pkg::ST_IDLE,
		strobeN:    hpr_pkg::RST_STROBE_N,
		busy:       1'b0,
		fetchPend:  1'b0,
		fetchReq:   1'b0,
		readyOut:   hpr_pkg::RST_READY_OUT,
		lastHalf:   1'b0,
		bumpOnRise: 1'b0,
		ackNode:    hpr_pkg::RST_ACK_NODE
	};

	// ==========================================================
	// Pin synchronisers
	// Each bit moves only once stages two and three agree
	hpr_pin_filter #(
		.WIDTH   (hpr_pkg::PORT_PIN_WIDTH),
		.RST_VAL (PIN_RST)
	) u_port_filter (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.pinIn   (portPins),
		.pinOut  (pinsSync)
	);

	// Ready pin crosses in before it reaches the ack node
	hpr_pin_filter #(
		.WIDTH   (1),
		.RST_VAL (READY_RST_N)
	) u_ready_filter (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.pinIn   (readyInN),
		.pinOut  (readySyncN)
	);

	// ==========================================================
	// Access decode
	always_comb begin
		curStrobeN = ~(pinsSync.strobeA ^ pinsSync.strobeB) | pinsSync.chipSelN;
		strobeFall = state_ff.strobeN & ~curStrobeN;
		strobeRise = ~state_ff.strobeN & curStrobeN;
		isDataReg  = (pinsSync.regSel == hpr_pkg::SEL_DATA_AUTOINC) ||
		             (pinsSync.regSel == hpr_pkg::SEL_DATA_FIXED);
		isRead     = (pinsSync.readWrite == hpr_pkg::RW_READ);

		isAutoInc    = (pinsSync.regSel == hpr_pkg::SEL_DATA_AUTOINC);
		isSecondHalf = (pinsSync.halfSel != hpr_pkg::HALF_FIRST);
		// Only data writes and autoinc reads leave work behind
		marksWork    = isDataReg && (!isRead || isAutoInc);
		// Data reads prefetch on the first halfword only
		wantsFetch   = isDataReg && isRead && !isSecondHalf;
	end

	// ==========================================================
	// Next state
	always_comb begin
		nxt_state          = state_ff;
		nxt_state.strobeN  = curStrobeN;
		nxt_state.fetchReq = 1'b0;

		// Completion first so a same-cycle set below wins
		if (workDone) begin
			nxt_state.busy = 1'b0;
		end
		if (fetchDone) begin
			nxt_state.fetchPend = 1'b0;
		end

		// Phase machine: one access in flight at a time
		unique case (state_ff.phase)
			hpr_pkg::ST_IDLE: begin
				if (strobeFall) begin
					// Selects caught here; the host may move them while the strobe is low
					nxt_state.lastHalf   = isSecondHalf;
					// only data write or autoinc read marks work
					nxt_state.bumpOnRise = marksWork;
					// fetch on first halfword data read
					if (wantsFetch) begin
						nxt_state.fetchReq  = 1'b1;
						nxt_state.fetchPend = 1'b1;
						nxt_state.phase     = hpr_pkg::ST_FETCH;
					end else begin
						nxt_state.phase = hpr_pkg::ST_ACCESS;
					end
				end
			end
			hpr_pkg::ST_FETCH: begin
				// Wait for the loaded word while the strobe stays low
				if (fetchDone || !state_ff.fetchPend) begin
					nxt_state.phase = hpr_pkg::ST_ACCESS;
				end
			end
			hpr_pkg::ST_ACCESS: begin
				// write is only complete once host holds strobe past ready low
				if (strobeRise) begin
					nxt_state.phase = hpr_pkg::ST_IDLE;
					if (state_ff.lastHalf && state_ff.bumpOnRise) begin
						nxt_state.busy = 1'b1;
					end
				end
			end
			default: begin
				nxt_state.phase = hpr_pkg::ST_IDLE;
			end
		endcase

		// Strobe lost while waiting: drop back to idle, fetch still completes
		if (state_ff.phase == hpr_pkg::ST_FETCH && strobeRise) begin
			nxt_state.phase = hpr_pkg::ST_IDLE;
		end

		// unfinished work or fetch keeps the port busy
		workPending        = nxt_state.busy | nxt_state.fetchPend;
		// ready gated by select, high only for pending work
		nxt_state.readyOut = ~pinsSync.chipSelN & workPending;

		// Node loaded high while start is asserted, so ack never lands in the following cycle
		// registered ready node
		nxt_state.ackNode = hostBus.chipSelN | readySyncN | ~hostBus.startN;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_ff <= CORE_RST;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ==========================================================
	// Outputs
	assign portReadyOut        = state_ff.readyOut;
	assign internalPortStrobeN = state_ff.strobeN;
	assign fetchReq            = state_ff.fetchReq;
	// Limitation: ack trails the ready pin by the synchroniser delay
	// ack from register and host select only
	assign transferAckN        = ~(~state_ff.ackNode & ~hostBus.chipSelN);

endmodule : hpr_host_port_ready

// ---- hpr_ready_monitor.sv ----
// Checker for the host port ready logic and its ack glue.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module hpr_ready_monitor (
	// Clock and reset
	input wire logic                    clk_sys,
	input wire logic                    sys_rst,
	// Watched ports
	input wire hpr_pkg::hpr_port_pins_t portPins,
	input wire logic                    portReadyOut,
	input wire logic                    internalPortStrobeN,
	input wire logic                    fetchReq,
	input wire hpr_pkg::hpr_host_bus_t  hostBus,
	input wire logic                    readyInN,
	input wire logic                    transferAckN
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// ==========================================================
	// Port side
	property p_ready_cs; portPins.chipSelN [*8] |-> !portReadyOut; endproperty
	a_ready_cs: assert property (p_ready_cs) else $error("ready while deselected");
	property p_strobe_cs; portPins.chipSelN [*8] |-> internalPortStrobeN; endproperty
	a_strobe_cs: assert property (p_strobe_cs) else $error("strobe while deselected");
	property p_fetch_pulse; fetchReq |=> !fetchReq; endproperty
	a_fetch_pulse: assert property (p_fetch_pulse) else $error("fetch request too long");
	property p_fetch_kind;
		fetchReq |-> portPins.regSel[0] && portPins.readWrite == hpr_pkg::RW_READ
			&& portPins.halfSel == hpr_pkg::HALF_FIRST && !portPins.chipSelN;
	endproperty
	a_fetch_kind: assert property (p_fetch_kind) else $error("fetch on wrong access");
	property p_fetch_ready; fetchReq |-> ##[0:2] portReadyOut; endproperty
	a_fetch_ready: assert property (p_fetch_ready) else $error("no ready after fetch");
	// ==========================================================
	// Ack glue
	// Ack low implies ready was seen low through the synchroniser
	property p_ack_cs;
		!transferAckN |-> !hostBus.chipSelN && (!$past(readyInN, 4) || !$past(readyInN, 5));
	endproperty
	a_ack_cs: assert property (p_ack_cs) else $error("ack without select");
	property p_ack_node; !transferAckN |-> $past(!hostBus.chipSelN && hostBus.startN); endproperty
	a_ack_node: assert property (p_ack_node) else $error("ack node cause wrong");
	property p_ack_quiet; readyInN [*8] |-> transferAckN; endproperty
	a_ack_quiet: assert property (p_ack_quiet) else $error("ack while port busy");
	property p_ack_raw; $fell(readyInN) |-> transferAckN; endproperty
	a_ack_raw: assert property (p_ack_raw) else $error("ack follows raw ready");
	c_fetch: cover property (fetchReq);
	c_ack: cover property (!transferAckN);
	c_busy_ctrl: cover property ($rose(portReadyOut) && portPins.regSel == hpr_pkg::SEL_CONTROL);
endmodule : hpr_ready_monitor

// ---- hpr_host_model.sv ----
// Host bus controller model driving port pins and host bus.
// Assumes one shared clock; the port chip select doubles as the strobe.
`timescale 1ns/1ns
module hpr_host_model (
	// Clock
	input wire logic                clk_sys,
	// Bus signals
	output hpr_pkg::hpr_port_pins_t portPins,
	output hpr_pkg::hpr_host_bus_t  hostBus,
	input wire logic                transferAckN,
	input wire logic                portReadyOut
);
	// Start held long: ready is seen only after the synchroniser delay
	localparam int START_HOLD = 10;
	initial begin
		portPins = '{1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 1'b1};
		hostBus = '{1'b1, 1'b1};
	end
	task access(input logic [1:0] sel, input logic half, input logic rw, output logic busy, output logic ok);
		int n;
		busy = 1'b0;
		ok = 1'b0;
		@(negedge clk_sys);
		portPins <= '{1'b0, 1'b0, 1'b1, sel, half, rw};
		hostBus <= '{1'b0, 1'b0};
		for (n = 0; n < 80 && !ok; n++) begin
			@(negedge clk_sys);
			busy |= portReadyOut;
			ok = (transferAckN === 1'b0);
			if (n == START_HOLD) hostBus.startN <= 1'b1;
		end
		// Released selects no longer show the old value
		portPins <= '{1'b1, 1'b0, 1'b0, ~sel, ~half, ~rw};
		hostBus.chipSelN <= 1'b1;
		repeat (8) @(negedge clk_sys);
	endtask : access
endmodule : hpr_host_model

// ---- tb_host_port_ready_sync_glue.sv ----
// Bench for the host port ready logic with a host bus model.
// Assumes the package, design, checker and model compile first.
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; $display("[ERR] %0t mismatch", $time); end end
module tb_host_port_ready_sync_glue;
	logic                    clk_sys;
	logic                    sys_rst = 1'b1;
	logic                    fetchDone = 1'b0;
	logic                    workDone = 1'b0;
	hpr_pkg::hpr_port_pins_t portPins;
	hpr_pkg::hpr_host_bus_t  hostBus;
	wire                     portReadyOut, internalPortStrobeN, fetchReq, transferAckN;
	int                      compares = 0, bad_count = 0, cyc = 0;
	hpr_host_port_ready hpr_host_port_ready_inst (.clk_sys, .sys_rst, .portPins, .portReadyOut,
		.internalPortStrobeN, .fetchReq, .fetchDone, .workDone, .hostBus, .readyInN(portReadyOut), .transferAckN);
	hpr_host_model hpr_host_model_inst (.clk_sys, .portPins, .hostBus, .transferAckN, .portReadyOut);
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			complete_run();
		end
	end
	task complete_run;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	task sc_fetch;
		logic b, k;
		int n;
		fork
			hpr_host_model_inst.access(hpr_pkg::SEL_DATA_FIXED, 1'b0, 1'b1, b, k);
			begin
				for (n = 0; n < 30 && fetchReq !== 1'b1; n++) @(negedge clk_sys);
				`CHK(n < 30, 1'b1)
				`CHK(internalPortStrobeN, 1'b0)
				repeat (6) @(negedge clk_sys);
				`CHK(portReadyOut, 1'b1)
				fetchDone = 1'b1;
				@(negedge clk_sys);
				fetchDone = 1'b0;
				`CHK(portReadyOut, 1'b0)
			end
		join
		`CHK(k, 1'b1)
	endtask : sc_fetch
	task sc_regs;
		logic b, k;
		for (int i = 0; i < 8; i++) begin
			hpr_host_model_inst.access(i[2] ? hpr_pkg::SEL_ADDRESS : hpr_pkg::SEL_CONTROL, i[1], i[0], b, k);
			`CHK(b, 1'b0)
			`CHK(k, 1'b1)
		end
	endtask : sc_regs
	task sc_busy;
		logic b, k;
		// Third pass: autoinc read second halfword alone, no fetch
		for (int i = 0; i < 3; i++) begin
			if (i < 2) begin
				hpr_host_model_inst.access(i ? hpr_pkg::SEL_DATA_FIXED : hpr_pkg::SEL_DATA_AUTOINC, 1'b0, 1'b0, b, k);
			end
			hpr_host_model_inst.access(i == 1 ? hpr_pkg::SEL_DATA_FIXED : hpr_pkg::SEL_DATA_AUTOINC, 1'b1, i == 2, b, k);
			`CHK(b, 1'b0)
			`CHK(portReadyOut, 1'b0)
			fork
				hpr_host_model_inst.access(hpr_pkg::SEL_CONTROL, 1'b0, 1'b1, b, k);
				begin
					repeat (12) @(negedge clk_sys);
					`CHK(portReadyOut, 1'b1)
					workDone = 1'b1;
					@(negedge clk_sys);
					workDone = 1'b0;
				end
			join
			`CHK(k, 1'b1)
		end
	endtask : sc_busy
	initial begin
		repeat (10) @(negedge clk_sys);
		sys_rst = 1'b0;
		sc_fetch();
		sc_regs();
		sc_busy();
		complete_run();
	end
endmodule : tb_host_port_ready_sync_glue
bind hpr_host_port_ready hpr_ready_monitor hpr_ready_monitor_inst (.clk_sys, .sys_rst, .portPins, .portReadyOut,
	.internalPortStrobeN, .fetchReq, .hostBus, .readyInN, .transferAckN);
